// ### include/cic_regs.svh
// Register offsets, field positions and reset values of the interrupt control block
//
// Behaviour
// (RULE_01) External pin enable set lets a pin event raise an interrupt; clear masks it.
// (RULE_02) Port change enable set lets an upper port change raise an interrupt.
// (RULE_03) Timer0 overflow sets its flag; only software writing zero clears it.
// (RULE_04) External pin event sets its flag; it holds until software clears it.
// (RULE_05) Any change on upper port pins 7..4 sets the port change flag.
// (RULE_06) Mismatch stays until port is read; flag keeps re-setting meanwhile.
// (RULE_07) Software reads the port before clearing the port change flag.
// (RULE_08) Flags set on their events regardless of any enable bit.
// (RULE_09) Peripheral interrupts reach the core only with peripheral enable bit 6 set.
// (RULE_10) Edge select one means rising edge, zero means falling edge.
// (RULE_11) Core interrupt needs global enable and an enabled set flag; peripherals need group enable.
`ifndef CIC_REGS_SVH
`define CIC_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses) and the control register word index
// ----------------------------------------------------------------
`define CIC_INTERRUPT_CONTROL_IDX 8'h0B
`define CIC_INTERRUPT_CONTROL_OFF 8'h2C
`define CIC_PORT_SNAPSHOT_OFF     8'h40
`define CIC_EDGE_CONFIG_OFF       8'h44

// ----------------------------------------------------------------
// Field positions of interrupt_control and the edge select bit of edge config
// ----------------------------------------------------------------
`define CIC_BIT_GLOBAL_EN   7
`define CIC_BIT_PERIPH_EN   6
`define CIC_BIT_TIMER_ZERO_COUNT_EN     5
`define CIC_BIT_EXT_EN      4
`define CIC_BIT_PORT_EN     3
`define CIC_BIT_TIMER_ZERO_COUNT_FLAG   2
`define CIC_BIT_EXT_FLAG    1
`define CIC_BIT_PORT_FLAG   0
`define CIC_BIT_EDGE_SELECT 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CIC_INTERRUPT_CONTROL_RST 8'h00
`define CIC_EDGE_CONFIG_RST       1'b1
`define CIC_PORT_SNAPSHOT_RST     4'h0

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define CIC_SYNC_FILL_CYCLES      2'h3

`endif

// ### include/cic_pkg.sv
// Types shared by the interrupt control block
package cic_pkg;
  typedef logic [7:0]  cic_byte_t;
  typedef logic [31:0] cic_word_t;
  typedef logic [3:0]  cic_nibble_t;
endpackage

// ### rtl/cic_core.sv
// Core interrupt control and flag register with APB slave
`timescale 1ns/1ps
`default_nettype none
`include "cic_regs.svh"

module cic_core
(
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire cic_pkg::cic_word_t  pwdata,
  output logic                     pready,
  output cic_pkg::cic_word_t       prdata,
  output logic                     pslverr,
  input  wire logic                timer0_overflow,
  input  wire logic                ext_irq_pin,
  input  wire cic_pkg::cic_nibble_t upper_port_pins,
  input  wire logic                second_port_read,
  input  wire logic                periph_irq_pending,
  output logic                     core_irq
);
  import cic_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic        ext_meta;
  logic        ext_sync;
  logic        ext_prev;
  cic_nibble_t port_meta;
  cic_nibble_t port_sync;
  logic        next_ext_meta;
  logic        next_ext_sync;
  logic        next_ext_prev;
  cic_nibble_t next_port_meta;
  cic_nibble_t next_port_sync;

  always_comb
  begin
    next_ext_meta  = ext_irq_pin;
    next_ext_sync  = ext_meta;
    next_ext_prev  = ext_sync;
    next_port_meta = upper_port_pins;
    next_port_sync = port_meta;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ext_meta  <= 1'b0;
      ext_sync  <= 1'b0;
      ext_prev  <= 1'b0;
      port_meta <= 4'h0;
      port_sync <= 4'h0;
    end
    else
    begin
      ext_meta  <= next_ext_meta;
      ext_sync  <= next_ext_sync;
      ext_prev  <= next_ext_prev;
      port_meta <= next_port_meta;
      port_sync <= next_port_sync;
    end
  end

  // ----------------------------------------------------------------
  // Synchroniser fill after reset
  // ----------------------------------------------------------------
  // Edges are ignored until the previous-sample flop holds a real pin value
  logic [1:0] fill_cnt;
  logic [1:0] next_fill_cnt;
  logic       sync_primed;

  always_comb
  begin
    sync_primed   = (fill_cnt == `CIC_SYNC_FILL_CYCLES);
    next_fill_cnt = sync_primed ? fill_cnt : fill_cnt + 2'h1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fill_cnt <= 2'h0;
    end
    else
    begin
      fill_cnt <= next_fill_cnt;
    end
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic wr_access;
  logic rd_access;
  logic hit_ctrl;
  logic hit_snap;
  logic hit_edge;

  always_comb
  begin
    hit_ctrl  = (paddr == `CIC_INTERRUPT_CONTROL_OFF);
    hit_snap  = (paddr == `CIC_PORT_SNAPSHOT_OFF);
    hit_edge  = (paddr == `CIC_EDGE_CONFIG_OFF);
    wr_access = psel && penable && pwrite;
    rd_access = psel && penable && !pwrite;
    pready    = 1'b1;
    pslverr   = psel && penable && !(hit_ctrl || hit_snap || hit_edge);
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Edge of the chosen polarity between two samples
  function automatic logic edge_seen
  (
    input logic now_level,
    input logic last_level,
    input logic rising
  );
    edge_seen = rising ? (now_level && !last_level)
                       : (!now_level && last_level);
  endfunction

  // Read value of a mapped register, zero elsewhere
  function automatic cic_word_t read_mux
  (
    input logic [7:0]  addr,
    input cic_byte_t   ctrl_value,
    input cic_nibble_t port_value,
    input logic        edge_value
  );
    read_mux = '0;
    if (addr == `CIC_INTERRUPT_CONTROL_OFF)
    begin
      read_mux = {24'h00_0000, ctrl_value};
    end
    else if (addr == `CIC_PORT_SNAPSHOT_OFF)
    begin
      read_mux = {28'h000_0000, port_value};
    end
    else if (addr == `CIC_EDGE_CONFIG_OFF)
    begin
      read_mux = {31'h0000_0000, edge_value};
    end
  endfunction

  // ----------------------------------------------------------------
  // Edge select
  // ----------------------------------------------------------------
  logic edge_select;
  logic next_edge_select;

  always_comb
  begin
    next_edge_select = edge_select;
    if (wr_access && hit_edge)
    begin
      next_edge_select = pwdata[`CIC_BIT_EDGE_SELECT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      edge_select <= `CIC_EDGE_CONFIG_RST;
    end
    else
    begin
      edge_select <= next_edge_select;
    end
  end

  // ----------------------------------------------------------------
  // Port snapshot
  // ----------------------------------------------------------------
  cic_nibble_t port_snapshot;
  cic_nibble_t next_port_snapshot;
  logic        port_refresh;

  always_comb
  begin
    // A port read, direct or over the bus, ends the mismatch
    port_refresh       = second_port_read || (rd_access && hit_snap);
    next_port_snapshot = port_refresh ? port_sync : port_snapshot; // see RULE_06
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      port_snapshot <= `CIC_PORT_SNAPSHOT_RST;
    end
    else
    begin
      port_snapshot <= next_port_snapshot;
    end
  end

  // ----------------------------------------------------------------
  // Pin event detection
  // ----------------------------------------------------------------
  logic ext_event;
  logic port_mismatch;

  always_comb
  begin
    ext_event     = sync_primed && edge_seen(ext_sync, ext_prev, edge_select); // see RULE_10
    // Mismatch holds until the port is read
    port_mismatch = (port_sync != port_snapshot); // see RULE_05, RULE_06
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  cic_byte_t ctrl;
  cic_byte_t next_ctrl;

  always_comb
  begin
    next_ctrl = ctrl;
    if (wr_access && hit_ctrl)
    begin
      next_ctrl = pwdata[7:0];
    end
    // Hardware sets win over a software clear in the same cycle
    if (timer0_overflow)
    begin
      next_ctrl[`CIC_BIT_TIMER_ZERO_COUNT_FLAG] = 1'b1; // see RULE_03, RULE_08
    end
    if (ext_event)
    begin
      next_ctrl[`CIC_BIT_EXT_FLAG] = 1'b1; // see RULE_04, RULE_08
    end
    if (port_mismatch)
    begin
      next_ctrl[`CIC_BIT_PORT_FLAG] = 1'b1; // see RULE_05, RULE_06, RULE_08
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl <= `CIC_INTERRUPT_CONTROL_RST;
    end
    else
    begin
      ctrl <= next_ctrl;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  cic_word_t next_prdata;

  always_comb
  begin
    // Captured in the setup phase so the word stands through the access phase
    next_prdata = '0;
    if (psel && !penable && !pwrite)
    begin
      next_prdata = read_mux(paddr, ctrl, port_sync, edge_select);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prdata <= '0;
    end
    else
    begin
      prdata <= next_prdata;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request to the core
  // ----------------------------------------------------------------
  logic next_core_irq;
  logic src_timer_zero_count;
  logic src_ext;
  logic src_port;
  logic src_periph;

  always_comb
  begin
    src_timer_zero_count   = ctrl[`CIC_BIT_TIMER_ZERO_COUNT_EN] && ctrl[`CIC_BIT_TIMER_ZERO_COUNT_FLAG]; // see RULE_11
    src_ext    = ctrl[`CIC_BIT_EXT_EN] && ctrl[`CIC_BIT_EXT_FLAG]; // see RULE_01
    src_port   = ctrl[`CIC_BIT_PORT_EN] && ctrl[`CIC_BIT_PORT_FLAG]; // see RULE_02
    src_periph = ctrl[`CIC_BIT_PERIPH_EN] && periph_irq_pending; // see RULE_09
    next_core_irq = ctrl[`CIC_BIT_GLOBAL_EN]
                    && (src_timer_zero_count || src_ext || src_port || src_periph); // see RULE_11
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      core_irq <= 1'b0;
    end
    else
    begin
      core_irq <= next_core_irq;
    end
  end

endmodule
`default_nettype wire

// ### verification/cic_pins.sv
// Model of the pins and timer that feed the block
`timescale 1ns/1ps
`default_nettype none
module cic_pins
(
  input  wire logic            clk,
  output logic                 t0_ovf,
  output logic                 ext_pin,
  output cic_pkg::cic_nibble_t port_pins
);
  initial
  begin
    t0_ovf = 1'b0;
    ext_pin = 1'b0;
    port_pins = 4'h0;
  end
  task automatic pulse_t0();
    @(posedge clk);
    t0_ovf <= 1'b1;
    @(posedge clk);
    t0_ovf <= 1'b0;
  endtask
  task automatic set_ext(input logic v);
    @(posedge clk);
    ext_pin <= v;
  endtask
  task automatic set_port(input logic [3:0] v);
    @(posedge clk);
    port_pins <= v;
  endtask
endmodule
`default_nettype wire

// ### verification/cic_chk.sv
// Port checker for the interrupt control block
`timescale 1ns/1ps
`default_nettype none
`include "cic_regs.svh"
module cic_chk
(
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire cic_pkg::cic_word_t pwdata,
  input wire logic               pready,
  input wire cic_pkg::cic_word_t prdata,
  input wire logic               pslverr,
  input wire logic               core_irq
);
  wire acc = psel && penable;
  wire map = paddr == `CIC_INTERRUPT_CONTROL_OFF || paddr == `CIC_PORT_SNAPSHOT_OFF
             || paddr == `CIC_EDGE_CONFIG_OFF;
  wire ctl_wr = acc && pwrite && paddr == `CIC_INTERRUPT_CONTROL_OFF;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence clr_gie;
    ctl_wr && !pwdata[`CIC_BIT_GLOBAL_EN];
  endsequence
  sequence set_timer_zero_count_pair;
    ctl_wr && pwdata[`CIC_BIT_GLOBAL_EN] && pwdata[`CIC_BIT_TIMER_ZERO_COUNT_EN] && pwdata[`CIC_BIT_TIMER_ZERO_COUNT_FLAG];
  endsequence
  sequence set_ext_pair;
    ctl_wr && pwdata[`CIC_BIT_GLOBAL_EN] && pwdata[`CIC_BIT_EXT_EN] && pwdata[`CIC_BIT_EXT_FLAG];
  endsequence
  sequence set_port_pair;
    ctl_wr && pwdata[`CIC_BIT_GLOBAL_EN] && pwdata[`CIC_BIT_PORT_EN] && pwdata[`CIC_BIT_PORT_FLAG];
  endsequence
  chk_ready_high: assert property (pready) else $error("pready low");
  chk_err_unmap: assert property (acc && !map |-> pslverr) else $error("no error");
  chk_err_map: assert property (acc && map |-> !pslverr) else $error("false error");
  chk_idle_quiet: assert property (!acc |-> prdata == 32'h0000_0000 && !pslverr)
    else $error("bus not quiet");
  chk_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("upper bits set");
  chk_unmap_zero: assert property (acc && !map |-> prdata == 32'h0000_0000)
    else $error("unmapped data");
  chk_reset_irq: assert property (disable iff (1'b0) rst |=> !core_irq)
    else $error("irq in reset");
  chk_gie_off: assert property (clr_gie |-> ##2 !core_irq)
    else $error("irq without global enable");
  chk_timer_zero_count_irq: assert property (set_timer_zero_count_pair |-> ##2 core_irq)
    else $error("no timer irq");
  chk_ext_irq: assert property (set_ext_pair |-> ##2 core_irq)
    else $error("no pin irq");
  chk_port_irq: assert property (set_port_pair |-> ##2 core_irq)
    else $error("no port irq");
endmodule
bind cic_core cic_chk i_chk (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .prdata, .pslverr, .core_irq);
`default_nettype wire

// ### verification/tb_core_interrupt_control.sv
// Testbench for the interrupt control block
`timescale 1ns/1ps
`default_nettype none
module tb_core_interrupt_control;
  import cic_pkg::*;
  logic        clk, pready, pslverr, irq, t0, ext, err;
  logic        rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        rd_evt = 1'b0, pend = 1'b0;
  logic [7:0]  paddr = 8'h00;
  cic_word_t   pwdata = 32'h0000_0000, prdata, rdata;
  cic_nibble_t pins;
  int          n_mismatch, checks_done, cyc;
  cic_core i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .timer0_overflow(t0), .ext_irq_pin(ext),
    .upper_port_pins(pins), .second_port_read(rd_evt),
    .periph_irq_pending(pend), .core_irq(irq));
  cic_pins i_pins (.clk, .t0_ovf(t0), .ext_pin(ext), .port_pins(pins));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic chk(input logic c, input string m);
    checks_done++;
    if (c !== 1'b1)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_irq(input logic [7:0] e, input logic q, input string m);
    repeat (2) @(posedge clk);
    chk(irq === q, m);
    apb(0, 8'h2C, 8'h00);
    chk(rdata[7:0] === e, m);
  endtask
  task automatic t_timer();
    i_pins.pulse_t0();
    repeat (3) @(posedge clk);
    rd_irq(8'h04, 1'b0, "timer flag");
    apb(1, 8'h2C, 8'h84);
    rd_irq(8'h84, 1'b0, "timer gate");
    apb(1, 8'h2C, 8'hA4);
    rd_irq(8'hA4, 1'b1, "timer irq");
    apb(1, 8'h2C, 8'h00);
    rd_irq(8'h00, 1'b0, "timer clear");
    $display("timer test done");
  endtask
  task automatic t_ext();
    apb(0, 8'h44, 8'h00);
    chk(rdata === 32'h0000_0001, "edge reset");
    i_pins.set_ext(1'b1);
    rd_irq(8'h02, 1'b0, "ext sync");
    repeat (4) @(posedge clk);
    rd_irq(8'h02, 1'b0, "ext rise");
    apb(1, 8'h2C, 8'h92);
    rd_irq(8'h92, 1'b1, "ext irq");
    apb(1, 8'h2C, 8'h82);
    rd_irq(8'h82, 1'b0, "ext masked");
    apb(1, 8'h44, 8'h00);
    apb(1, 8'h2C, 8'h00);
    i_pins.set_ext(1'b0);
    repeat (6) @(posedge clk);
    rd_irq(8'h02, 1'b0, "ext fall");
    apb(1, 8'h2C, 8'h00);
    i_pins.set_ext(1'b1);
    repeat (6) @(posedge clk);
    rd_irq(8'h00, 1'b0, "ext no rise");
    $display("ext test done");
  endtask
  task automatic t_port();
    i_pins.set_port(4'h5);
    repeat (6) @(posedge clk);
    rd_irq(8'h01, 1'b0, "port flag");
    apb(1, 8'h2C, 8'h89);
    rd_irq(8'h89, 1'b1, "port irq");
    apb(1, 8'h2C, 8'h80);
    repeat (3) @(posedge clk);
    rd_irq(8'h81, 1'b0, "port mismatch");
    rd_evt <= 1'b1;
    @(posedge clk);
    rd_evt <= 1'b0;
    apb(1, 8'h2C, 8'h00);
    repeat (3) @(posedge clk);
    rd_irq(8'h00, 1'b0, "port cleared");
    i_pins.set_port(4'hA);
    repeat (6) @(posedge clk);
    apb(0, 8'h40, 8'h00);
    chk(rdata === 32'h0000_000A, "port snapshot");
    apb(1, 8'h2C, 8'h00);
    repeat (3) @(posedge clk);
    rd_irq(8'h00, 1'b0, "snapshot ends mismatch");
    $display("port test done");
  endtask
  task automatic t_periph();
    pend <= 1'b1;
    apb(1, 8'h2C, 8'h80);
    rd_irq(8'h80, 1'b0, "periph gated");
    apb(1, 8'h2C, 8'hC0);
    rd_irq(8'hC0, 1'b1, "periph irq");
    pend <= 1'b0;
    apb(0, 8'h30, 8'h00);
    chk(err === 1'b1 && rdata === 32'h0000_0000, "unmapped");
    $display("periph test done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd_irq(8'h00, 1'b0, "reset value");
    t_timer();
    t_ext();
    t_port();
    t_periph();
    final_report();
  end
endmodule
`default_nettype wire
